// ---- hw/serial_fifo_control.sv ----
/*
 * Serial channel FIFO and line control with an APB register slave: transmit
 * trigger, modem handshake gating, FIFO flushes, loop-back, sticky interrupts.
 * Assumes APB master on mclk, a character engine on mclk outside this block
 * that pulls transmit bytes and pushes received bytes, and raw pins for cts_n
 * and rxd. The engine honours tx_allowed before starting a character.
 */
// What this block does
// - Trigger codes 01, 10, 11 give thresholds of 4, 2 and 0 bytes left.
// - Trigger code 00 gives a threshold of 8 untransmitted bytes.
// - Modem enable set: CTS gates transmission, RTS driven as flow control.
// - Modem disabled: CTS taken as always asserted, internal RTS held at 0.
// - Modem enable exists only on channels 0 and 1; reads 0 elsewhere.
// - Writing 1 to transmit flush empties the transmit FIFO.
// - Writing 1 to receive flush empties the receive FIFO.
// - Reset empties both FIFOs and flush bits read 0.
// - Loop-back routes the transmit output to the receive input internally.
`timescale 1ns/100ps
`default_nettype none
module serial_fifo_control
    import fifo_ctl_pkg::*;
#(
    parameter int CHANNEL = 0,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Character engine side
    input wire logic tx_pop,
    output byte_beat_t tx_head,
    output logic tx_allowed,
    input wire byte_beat_t rx_beat,
    input wire logic eng_txd,
    output logic eng_rxd,
    // Pins
    input wire logic rxd_pin,
    input wire logic cts_n_pin,
    output line_out_t line_out
);
    logic [15:0] ctrl_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic [7:0] tx_data_r;
    logic [31:0] prdata_r;
    logic rts_n_r;
    logic txd_r;
    logic tx_flush;
    logic rx_flush;
    logic tx_push;
    logic rx_pop;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
    logic [CNT_W-1:0] threshold;
    logic tx_below;
    logic tx_below_d_r;
    logic cts_n_s;
    logic rxd_s;
    logic cts_active;
    logic modem_en;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [ST_W-1:0] set_ev;
    logic [ST_W-1:0] clr_ev;
    logic [31:0] rd_mux;

    // APB decode; every access completes in its first access cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    always_comb begin
        unique case (paddr)
            OFF_FIFO_CONTROL, OFF_STATUS, OFF_MASK,
            OFF_LEVELS, OFF_TX_DATA, OFF_RX_DATA: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    // Modem enable is only a real bit on channels 0 and 1
    assign modem_en = (CHANNEL < 2) ? ctrl_r[BIT_MODEM_EN] : 1'b0;

    // Control register; flush bits are write-pulses and never stored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= FIFO_CONTROL_RESET;
        end else if (wr_en && paddr == OFF_FIFO_CONTROL) begin
            ctrl_r <= pwdata[15:0];
            ctrl_r[BIT_TX_FLUSH] <= 1'b0;
            ctrl_r[BIT_RX_FLUSH] <= 1'b0;
            if (CHANNEL >= 2) begin
                ctrl_r[BIT_MODEM_EN] <= 1'b0;
            end
        end
    end

    // Writing zero leaves the FIFOs alone
    assign tx_flush = wr_en && paddr == OFF_FIFO_CONTROL && pwdata[BIT_TX_FLUSH];
    assign rx_flush = wr_en && paddr == OFF_FIFO_CONTROL && pwdata[BIT_RX_FLUSH];

    // Software pushes bytes through the transmit data word
    assign tx_push = wr_en && paddr == OFF_TX_DATA;
    assign rx_pop = rd_en && paddr == OFF_RX_DATA;

    byte_fifo #(
        .DEPTH(DEPTH),
        .AW($clog2(DEPTH))
    ) u_tx_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(tx_flush),
        .push(tx_push),
        .push_data(pwdata[7:0]),
        .pop(tx_pop && tx_allowed),
        .head(tx_q),
        .count(tx_cnt),
        .full(tx_full),
        .empty(tx_empty)
    );

    byte_fifo #(
        .DEPTH(DEPTH),
        .AW($clog2(DEPTH))
    ) u_rx_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(rx_flush),
        .push(rx_beat.valid),
        .push_data(rx_beat.data),
        .pop(rx_pop),
        .head(rx_q),
        .count(rx_cnt),
        .full(rx_full),
        .empty(rx_empty)
    );

    // Pins come from outside the clock domain
    sync2 #(
        .RESET_VAL(1'b1)
    ) u_cts_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(cts_n_pin),
        .q(cts_n_s)
    );

    sync2 #(
        .RESET_VAL(1'b1)
    ) u_rxd_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(rxd_pin),
        .q(rxd_s)
    );

    // Trigger code to threshold of untransmitted bytes
    always_comb begin
        unique case (tx_trigger_t'(ctrl_r[BIT_TRG_HI:BIT_TRG_LO]))
            TRG_8: threshold = THR_8;
            TRG_4: threshold = THR_4;
            TRG_2: threshold = THR_2;
            TRG_0: threshold = THR_0;
        endcase
    end
    assign tx_below = (tx_cnt <= threshold);

    // Flag on the falling edge of occupancy past the threshold; level seen at
    // reset would fire at once, so the delayed copy starts high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_below_d_r <= 1'b1;
        end else begin
            tx_below_d_r <= tx_below;
        end
    end

    // Handshake gating; disabled modem means CTS counts as always asserted
    assign cts_active = modem_en ? !cts_n_s : 1'b1;
    assign tx_allowed = cts_active && !tx_empty;

    // RTS: asserted while room remains in the receive FIFO
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rts_n_r <= 1'b0;
        end else if (modem_en) begin
            rts_n_r <= rx_full;
        end else begin
            rts_n_r <= 1'b0;
        end
    end

    // Loop-back: receive sees own transmit, line idles high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txd_r <= 1'b1;
        end else begin
            txd_r <= ctrl_r[BIT_LOOP] ? 1'b1 : eng_txd;
        end
    end
    assign eng_rxd = ctrl_r[BIT_LOOP] ? eng_txd : rxd_s;
    assign line_out.txd = txd_r;
    assign line_out.rts_n = rts_n_r;

    // Interrupt events
    assign set_ev[ST_TX_EMPTY] = tx_below && !tx_below_d_r;
    assign set_ev[ST_RX_READY] = rx_beat.valid;
    assign set_ev[ST_TX_OVER] = tx_push && tx_full;
    assign set_ev[ST_RX_OVER] = rx_beat.valid && rx_full;
    assign clr_ev = (wr_en && paddr == OFF_STATUS) ? pwdata[ST_W-1:0] : '0;

    // Sticky status, write one to clear; a coincident set wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~clr_ev) | set_ev;
        end
    end

    // Mask register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= '0;
        end else if (wr_en && paddr == OFF_MASK) begin
            mask_r <= pwdata[ST_W-1:0];
        end
    end
    assign irq = |(status_r & mask_r);

    // Head of transmit FIFO registered for the transmit data readback; the engine sees it unregistered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_r <= '0;
        end else begin
            tx_data_r <= tx_q;
        end
    end
    assign tx_head.valid = !tx_empty;
    assign tx_head.data = tx_q;

    // Read mux
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            OFF_FIFO_CONTROL: begin
                rd_mux[15:0] = ctrl_r;
                rd_mux[BIT_MODEM_EN] = modem_en;
            end
            OFF_STATUS: rd_mux[ST_W-1:0] = status_r;
            OFF_MASK: rd_mux[ST_W-1:0] = mask_r;
            OFF_LEVELS: begin
                rd_mux[CNT_W-1:0] = rx_cnt;
                rd_mux[LEVEL_RX_SHIFT+CNT_W-1:LEVEL_RX_SHIFT] = tx_cnt;
            end
            OFF_TX_DATA: rd_mux[7:0] = tx_data_r;
            OFF_RX_DATA: rd_mux[7:0] = rx_empty ? 8'h00 : rx_q;
            default: rd_mux = '0;
        endcase
    end

    // Read data held in a flop loaded in the setup cycle; valid through the access cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= '0;
        end else if (psel && !penable) begin
            prdata_r <= rd_mux;
        end
    end
    assign prdata = prdata_r;
endmodule : serial_fifo_control
`default_nettype wire

// ---- hw/fifo_ctl_pkg.sv ----
/*
 * Package for the serial FIFO control block: register map, field positions,
 * reset values, trigger codes, status bits and the carrier structs.
 * Assumes a 32-bit APB with byte addresses and one register per aligned word.
 */
package fifo_ctl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_FIFO_CONTROL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_LEVELS = 8'h0C;
    localparam logic [7:0] OFF_TX_DATA = 8'h10;
    localparam logic [7:0] OFF_RX_DATA = 8'h14;

    // Field positions in fifo_control
    localparam int BIT_LOOP = 0;
    localparam int BIT_RX_FLUSH = 1;
    localparam int BIT_TX_FLUSH = 2;
    localparam int BIT_MODEM_EN = 3;
    localparam int BIT_TRG_LO = 4;
    localparam int BIT_TRG_HI = 5;
    localparam logic [15:0] FIFO_CONTROL_RESET = 16'h0000;

    // Status and mask bits
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX_READY = 1;
    localparam int ST_TX_OVER = 2;
    localparam int ST_RX_OVER = 3;
    localparam int ST_W = 4;

    // FIFO geometry
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int LEVEL_RX_SHIFT = 8;

    // Transmit trigger codes and thresholds (untransmitted bytes)
    typedef enum logic [1:0] {
        TRG_8 = 2'b00,
        TRG_4 = 2'b01,
        TRG_2 = 2'b10,
        TRG_0 = 2'b11
    } tx_trigger_t;
    localparam logic [CNT_W-1:0] THR_8 = 5'h08;
    localparam logic [CNT_W-1:0] THR_4 = 5'h04;
    localparam logic [CNT_W-1:0] THR_2 = 5'h02;
    localparam logic [CNT_W-1:0] THR_0 = 5'h00;

    // Byte stream carrier
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

    // Modem/line pin group as seen by the core
    typedef struct packed {
        logic txd;
        logic rts_n;
    } line_out_t;

endpackage : fifo_ctl_pkg

// ---- hw/byte_fifo.sv ----
/*
 * Sixteen-entry byte FIFO with synchronous flush and an occupancy count.
 * Assumes push/pop come from logic on mclk; pushes when full are dropped.
 */
`timescale 1ns/100ps
`default_nettype none
module byte_fifo
    import fifo_ctl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    output logic [7:0] head,
    output logic [CNT_W-1:0] count,
    output logic full,
    output logic empty
);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [CNT_W-1:0] cnt_r;
    logic do_push;
    logic do_pop;

    assign full = (cnt_r == CNT_W'(DEPTH));
    assign empty = (cnt_r == '0);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign count = cnt_r;
    assign head = mem[rd_r];

    // Storage needs no reset; pointers define what is valid
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_r] <= push_data;
        end
    end

    // Pointers and count; flush discards everything in one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (flush) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_push) begin
                wr_r <= wr_r + AW'(1);
            end
            if (do_pop) begin
                rd_r <= rd_r + AW'(1);
            end
            if (do_push && !do_pop) begin
                cnt_r <= cnt_r + CNT_W'(1);
            end else if (do_pop && !do_push) begin
                cnt_r <= cnt_r - CNT_W'(1);
            end
        end
    end
endmodule : byte_fifo
`default_nettype wire

// ---- hw/sync2.sv ----
/*
 * Two flip-flop synchroniser for a single level from a pin.
 * Assumes the input is asynchronous to mclk; adds two cycles of latency.
 */
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic q_r;

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            q_r <= RESET_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
    assign q = q_r;
endmodule : sync2
`default_nettype wire

// ---- dv/fifo_ctl_monitor.sv ----
/*
 * Port checker for serial_fifo_control, bound into that module.
 * Assumes APB writes land at the access edge and the design's field map.
 */
`timescale 1ns/100ps
`default_nettype none
module fifo_ctl_monitor
    import fifo_ctl_pkg::*;
#(
    parameter int CHANNEL = 0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic cts_n_pin,
    input wire logic eng_txd,
    input wire logic eng_rxd,
    input wire logic tx_allowed,
    input wire byte_beat_t tx_head,
    input wire line_out_t line_out
);
    logic loop_r;
    logic mod_r;
    logic [1:0] trg_r;
    logic wr_ctl;
    logic rd_ctl;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == OFF_FIFO_CONTROL;
    assign rd_ctl = psel && penable && !pwrite && paddr == OFF_FIFO_CONTROL;
    // Shadow of stored control bits, so outputs can be tied to them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loop_r <= 1'b0;
            mod_r <= 1'b0;
            trg_r <= 2'b00;
        end else if (wr_ctl) begin
            loop_r <= pwdata[BIT_LOOP];
            mod_r <= pwdata[BIT_MODEM_EN] && (CHANNEL < 2);
            trg_r <= pwdata[BIT_TRG_HI:BIT_TRG_LO];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_loop_rx;
        loop_r |-> eng_rxd == eng_txd;
    endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("loop rx not tx");
    property p_loop_txd;
        $past(loop_r) |-> line_out.txd;
    endproperty
    a_loop_txd: assert property (p_loop_txd) else $error("txd not idle");
    property p_rts_off;
        !$past(mod_r) |-> line_out.rts_n == 1'b0;
    endproperty
    a_rts_off: assert property (p_rts_off) else $error("rts not 0");
    property p_cts_off;
        !mod_r && tx_head.valid |-> tx_allowed;
    endproperty
    a_cts_off: assert property (p_cts_off) else $error("tx held");
    property p_cts_on;
        mod_r && $past(cts_n_pin, 2) && $past(cts_n_pin, 3) |-> !tx_allowed;
    endproperty
    a_cts_on: assert property (p_cts_on) else $error("cts ignored");
    property p_flush_tx;
        wr_ctl && pwdata[BIT_TX_FLUSH] |=> !tx_head.valid;
    endproperty
    a_flush_tx: assert property (p_flush_tx) else $error("tx not flushed");
    property p_rd_flush;
        rd_ctl |-> prdata[BIT_TX_FLUSH:BIT_RX_FLUSH] == 2'b00;
    endproperty
    a_rd_flush: assert property (p_rd_flush) else $error("flush bits set");
    property p_rd_trg;
        rd_ctl |-> prdata[BIT_TRG_HI:BIT_TRG_LO] == trg_r;
    endproperty
    a_rd_trg: assert property (p_rd_trg) else $error("trigger readback");
    property p_rd_mod;
        rd_ctl |-> prdata[BIT_MODEM_EN] == mod_r;
    endproperty
    a_rd_mod: assert property (p_rd_mod) else $error("modem readback");
endmodule : fifo_ctl_monitor
bind serial_fifo_control fifo_ctl_monitor #(.CHANNEL(CHANNEL)) mon (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .cts_n_pin(cts_n_pin),
    .eng_txd(eng_txd), .eng_rxd(eng_rxd), .tx_allowed(tx_allowed),
    .tx_head(tx_head), .line_out(line_out));
`default_nettype wire

// ---- dv/line_peer.sv ----
/*
 * Remote serial device: talks on rxd while granted, holds off via cts.
 * Assumes mclk-timed pins; idle line sits at mark.
 */
`timescale 1ns/100ps
`default_nettype none
module line_peer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic rts_n,
    output logic cts_n_pin,
    output logic rxd_pin
);
    // Talks only while our rts grants it, so a full receiver is respected
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_pin <= 1'b1;
            cts_n_pin <= 1'b1;
        end else begin
            rxd_pin <= rts_n ? 1'b1 : !rxd_pin;
            cts_n_pin <= hold;
        end
    end
endmodule : line_peer
`default_nettype wire

// ---- dv/test_serial_fifo_control.sv ----
/*
 * Testbench for serial_fifo_control: APB master, engine stub, line peer.
 * Assumes zero-wait APB and the register map of fifo_ctl_pkg.
 */
`timescale 1ns/100ps
`default_nettype none
module test_serial_fifo_control
    import fifo_ctl_pkg::*;
;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, tx_pop;
    logic tx_allowed, eng_txd, eng_rxd, cts_n_pin, rxd_pin, hold;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    byte_beat_t tx_head, rx_beat;
    line_out_t line_out;
    int err_count, tests_run, cyc;
    note_t notes[$];
    note_t n;
    serial_fifo_control #(.CHANNEL(0)) dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .tx_pop(tx_pop), .tx_head(tx_head), .tx_allowed(tx_allowed),
        .rx_beat(rx_beat), .eng_txd(eng_txd), .eng_rxd(eng_rxd),
        .rxd_pin(rxd_pin), .cts_n_pin(cts_n_pin), .line_out(line_out));
    line_peer peer (.mclk(mclk), .rst_n(rst_n), .hold(hold), .rts_n(line_out.rts_n),
        .cts_n_pin(cts_n_pin), .rxd_pin(rxd_pin));
    always #10 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Reads leave a note; the watcher below settles it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : ZERO;
        if (!w) notes.push_back('{d & m, m, a > OFF_RX_DATA});
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic tx_push(input int k);
        repeat (k) apb(1'b1, OFF_TX_DATA, rnd() & 32'h0000_00ff, ALL);
    endtask : tx_push
    task automatic rx_push(input int k);
        logic [31:0] r;
        repeat (k) begin
            r = rnd();
            @(posedge mclk);
            rx_beat <= '{1'b1, r[7:0]};
            @(posedge mclk);
            rx_beat.valid <= 1'b0;
        end
    endtask : rx_push
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // Oldest note against each read answer, old values seen before NBA
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            n = notes.pop_front();
            chk(prdata & n.m, n.d);
            chk(32'(pslverr), 32'(n.e));
        end
    end
    // Hang guard, run needs about 265 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 6000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        int thr[4] = '{8, 4, 2, 0};
        logic [31:0] r;
        {mclk, rst_n, psel, penable, pwrite, tx_pop, eng_txd} = 7'h00;
        paddr = 8'h00;
        pwdata = ZERO;
        rx_beat = '0;
        hold = 1'b1;
        seed = 32'h0000_0003;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, OFF_FIFO_CONTROL, ZERO, ALL);
        apb(1'b0, OFF_LEVELS, ZERO, ALL);
        apb(1'b0, 8'hfc, ZERO, ALL);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFF_FIFO_CONTROL, 32'(k << BIT_TRG_LO) | 32'h0000_0004, ALL);
            apb(1'b1, OFF_STATUS, 32'h0000_000f, ALL);
            tx_push(thr[k] + 1);
            apb(1'b0, OFF_STATUS, ZERO, 32'h0000_0001);
            @(posedge mclk);
            tx_pop <= 1'b1;
            @(posedge mclk);
            tx_pop <= 1'b0;
            apb(1'b0, OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
            apb(1'b0, OFF_LEVELS, 32'(thr[k]) << 8, 32'h0000_1f00);
        end
        // Interrupt raised through the mask, then cleared
        @(negedge mclk) chk(32'(irq), ZERO);
        apb(1'b1, OFF_MASK, 32'h0000_0001, ALL);
        @(negedge mclk) chk(32'(irq), 32'h0000_0001);
        apb(1'b1, OFF_STATUS, 32'h0000_0001, ALL);
        @(negedge mclk) chk(32'(irq), ZERO);
        apb(1'b1, OFF_MASK, ZERO, ALL);
        tx_push(5);
        rx_push(3);
        apb(1'b0, OFF_LEVELS, 32'h0000_0503, 32'h0000_1f1f);
        apb(1'b1, OFF_FIFO_CONTROL, 32'h0000_0004, ALL);
        apb(1'b0, OFF_LEVELS, 32'h0000_0003, 32'h0000_1f1f);
        apb(1'b1, OFF_FIFO_CONTROL, 32'h0000_0002, ALL);
        apb(1'b0, OFF_LEVELS, ZERO, 32'h0000_1f1f);
        // Known byte through the receive FIFO, read back through the data word
        @(posedge mclk);
        rx_beat <= '{1'b1, 8'h5a};
        @(posedge mclk);
        rx_beat.valid <= 1'b0;
        apb(1'b0, OFF_RX_DATA, 32'h0000_005a, ALL);
        apb(1'b0, OFF_LEVELS, ZERO, 32'h0000_001f);
        apb(1'b0, OFF_FIFO_CONTROL, ZERO, 32'h0000_0006);
        // Modem gating with the peer holding off
        tx_push(1);
        @(negedge mclk) chk(32'(tx_allowed), 32'h0000_0001);
        chk(32'(line_out.rts_n), ZERO);
        apb(1'b1, OFF_FIFO_CONTROL, 32'h0000_0008, ALL);
        repeat (3) @(posedge mclk);
        hold <= 1'b0;
        @(negedge mclk) chk(32'(tx_allowed), ZERO);
        repeat (4) @(posedge mclk);
        @(negedge mclk) chk(32'(tx_allowed), 32'h0000_0001);
        rx_push(16);
        repeat (2) @(posedge mclk);
        @(negedge mclk) chk(32'(line_out.rts_n), 32'h0000_0001);
        apb(1'b0, OFF_FIFO_CONTROL, 32'h0000_0008, 32'h0000_0008);
        // Modem enable cleared with a receive flush, then loop-back checked
        apb(1'b1, OFF_FIFO_CONTROL, 32'h0000_0002, ALL);
        apb(1'b1, OFF_FIFO_CONTROL, 32'h0000_0001, ALL);
        repeat (8) begin
            @(posedge mclk);
            r = rnd();
            eng_txd <= r[0];
            @(negedge mclk) chk(32'(eng_rxd), 32'(eng_txd));
            chk(32'(line_out.txd), 32'h0000_0001);
        end
        apb(1'b1, OFF_FIFO_CONTROL, ZERO, ALL);
        final_report();
    end
endmodule : test_serial_fifo_control
`default_nettype wire
